// ===== lpc_rx_buf.sv
// link port package and receive buffer memory with registered read data
package lpc_pkg;
    // reference clock made from CLK_SYS: one reference period in sys cycles
    localparam int REF_DIV = 2;
    localparam int RX_DEPTH = 16;
    localparam int ACK_MARGIN = 4;
    localparam int DIV_W = 8;
    localparam int HALF_W = 9;
    localparam int DATA_W = 8;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [HALF_W-1:0] HALF_ZERO = 9'h000;
    localparam logic [HALF_W-1:0] HALF_ONE = 9'h001;
    typedef enum logic [2:0] {
        LPC_TX_IDLE = 3'b001,
        LPC_TX_HIGH = 3'b010,
        LPC_TX_LOW = 3'b100
    } lpc_tx_e;
endpackage : lpc_pkg

`timescale 1ns/10ps
`default_nettype none
module lpc_rx_buf #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16,
    parameter int AW = $clog2(DEPTH)
) (
    // clock
    input wire logic clk,
    // write side
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [WIDTH-1:0] wdata,
    // read side
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata
);
    import lpc_pkg::*;
    typedef struct packed {
        logic [WIDTH-1:0] rdata;
    } lpc_mem_s;
    logic [WIDTH-1:0] mem [DEPTH];
    lpc_mem_s s;
    lpc_mem_s next_s;

    // write-first so a byte landing in an empty buffer shows at once
    always_comb begin
        next_s = s;
        if (we && waddr == raddr) begin
            next_s.rdata = wdata;
        end else begin
            next_s.rdata = mem[raddr];
        end
    end

    always_ff @(posedge clk) begin
        s <= next_s;
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    assign rdata = s.rdata;
endmodule : lpc_rx_buf
`default_nettype wire

// ===== lpc_link_port.sv
// link port: byte-wide link clock generation, transmit and receive
// Function
// - in transmit mode the link clock runs at reference / (2 x divider) for divider 1..255.
// - a divider of zero gives a link clock at the undivided reference rate.
// - the receiver pulls acknowledge low only after the first byte and when its buffer is nearly full.
// - the receiver captures data on the falling edge of the link clock.
// - the transmitter changes data at the rising edge so it is stable at the next falling edge.
// - a held-off transmitter drives the clock low again only after acknowledge returns high.
// - the transmitter samples acknowledge before each falling edge and holds the clock high while it is low.
`timescale 1ns/10ps
`default_nettype none
module lpc_link_port #(
    parameter int DEPTH = lpc_pkg::RX_DEPTH,
    parameter int MARGIN = lpc_pkg::ACK_MARGIN
) (
    // clock and reset
    input wire logic CLK_SYS,
    input wire logic RST_N,
    // mode and divider
    input wire logic TX_ENABLE,
    input wire logic RX_ENABLE,
    input wire logic [lpc_pkg::DIV_W-1:0] LINK_DIVIDER_REGISTER,
    // transmit user side
    input wire logic [lpc_pkg::DATA_W-1:0] TX_DATA,
    input wire logic TX_VALID,
    output logic TX_READY,
    // receive user side
    output logic [lpc_pkg::DATA_W-1:0] RX_DATA,
    output logic RX_VALID,
    input wire logic RX_READY,
    // link clock pin
    input wire logic LINK_CLOCK_IN,
    output logic LINK_CLOCK_OUT,
    output logic LINK_CLOCK_OE_N,
    // link acknowledge pin
    input wire logic LINK_ACKNOWLEDGE_IN,
    output logic LINK_ACKNOWLEDGE_OUT,
    output logic LINK_ACKNOWLEDGE_OE_N,
    // link data pins
    input wire logic [lpc_pkg::DATA_W-1:0] LINK_DATA_IN,
    output logic [lpc_pkg::DATA_W-1:0] LINK_DATA_OUT,
    output logic LINK_DATA_OE_N
);
    import lpc_pkg::*;
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW:0] CNT_ZERO = '0;
    localparam logic [AW:0] CNT_FULL = (AW+1)'(DEPTH);
    localparam logic [AW:0] CNT_NEAR = (AW+1)'(DEPTH - MARGIN);
    localparam logic [AW-1:0] PTR_ONE = (AW)'(1);
    localparam logic [AW:0] CNT_ONE = (AW+1)'(1);

    typedef struct packed {
        lpc_tx_e st;
        logic [HALF_W-1:0] cnt;
        logic clk_o;
        logic [DATA_W-1:0] dat_o;
        logic drv_tx;
        logic drv_rx;
        logic ack_o;
        logic [1:0] ack_s;
        logic [1:0] clk_s;
        logic clk_d;
        logic [DATA_W-1:0] dat_s1;
        logic [DATA_W-1:0] dat_s2;
        logic first;
        logic [AW-1:0] wr_ptr;
        logic [AW-1:0] rd_ptr;
        logic [AW:0] level;
    } lpc_state_s;

    lpc_state_s s;
    lpc_state_s next_s;
    logic tx_take;
    logic rx_on;
    logic rx_fall;
    logic rx_wr;
    logic rx_rd;
    logic [HALF_W-1:0] half;

    // sys cycles per link clock half period
    function automatic logic [HALF_W-1:0] half_cycles(
        input logic [DIV_W-1:0] div
    );
        if (div == '0) begin
            half_cycles = HALF_W'(REF_DIV / 2);
        end else begin
            half_cycles = HALF_W'(int'(div) * REF_DIV);
        end
    endfunction : half_cycles

    // reload value: the counter runs from half-1 down to zero
    function automatic logic [HALF_W-1:0] half_load(
        input logic [HALF_W-1:0] h
    );
        half_load = h - HALF_ONE;
    endfunction : half_load

    // pointers wrap at the depth, which must be a power of two
    function automatic logic [AW-1:0] ptr_step(
        input logic [AW-1:0] p
    );
        ptr_step = p + PTR_ONE;
    endfunction : ptr_step

    // occupancy after one cycle of writes and pops
    function automatic logic [AW:0] level_step(
        input logic [AW:0] lvl,
        input logic wr,
        input logic rd
    );
        level_step = lvl;
        if (wr && !rd) begin
            level_step = lvl + CNT_ONE;
        end else if (rd && !wr) begin
            level_step = lvl - CNT_ONE;
        end
    endfunction : level_step

    assign half = half_cycles(LINK_DIVIDER_REGISTER);
    // transmit wins when both modes are asked for
    assign rx_on = RX_ENABLE && !TX_ENABLE;
    // the partner must keep its clock well below CLK_SYS for edges to be seen
    assign rx_fall = s.clk_d && !s.clk_s[1];
    assign rx_wr = rx_on && rx_fall && s.level != CNT_FULL;
    assign rx_rd = RX_VALID && RX_READY;
    assign TX_READY = TX_ENABLE && (s.st == LPC_TX_IDLE ||
        (s.st == LPC_TX_LOW && s.cnt == HALF_ZERO));
    assign tx_take = TX_READY && TX_VALID;

    always_comb begin
        next_s = s;
        next_s.ack_s = {s.ack_s[0], LINK_ACKNOWLEDGE_IN};
        next_s.clk_s = {s.clk_s[0], LINK_CLOCK_IN};
        next_s.clk_d = s.clk_s[1];
        // data word crosses unencoded: it stands for cycles around the fall
        next_s.dat_s1 = LINK_DATA_IN;
        next_s.dat_s2 = s.dat_s1;
        next_s.drv_tx = TX_ENABLE;
        next_s.drv_rx = rx_on;
        if (s.cnt != HALF_ZERO) begin
            next_s.cnt = s.cnt - HALF_ONE;
        end
        unique case (s.st)
            LPC_TX_IDLE: begin
                next_s.clk_o = 1'b0;
                if (tx_take) begin
                    next_s.clk_o = 1'b1;
                    next_s.dat_o = TX_DATA;
                    next_s.cnt = half_load(half);
                    next_s.st = LPC_TX_HIGH;
                end
            end
            LPC_TX_HIGH: begin
                // acknowledge is sampled only at the end of the high phase
                if (s.cnt == HALF_ZERO && s.ack_s[1]) begin
                    next_s.clk_o = 1'b0;
                    next_s.cnt = half_load(half);
                    next_s.st = LPC_TX_LOW;
                end
            end
            LPC_TX_LOW: begin
                if (tx_take) begin
                    next_s.clk_o = 1'b1;
                    next_s.dat_o = TX_DATA;
                    next_s.cnt = half_load(half);
                    next_s.st = LPC_TX_HIGH;
                end else if (s.cnt == HALF_ZERO) begin
                    next_s.st = LPC_TX_IDLE;
                end
            end
        endcase
        if (rx_wr) begin
            next_s.wr_ptr = ptr_step(s.wr_ptr);
            next_s.first = 1'b1;
        end
        if (rx_rd) begin
            next_s.rd_ptr = ptr_step(s.rd_ptr);
        end
        next_s.level = level_step(s.level, rx_wr, rx_rd);
        if (!rx_on) begin
            next_s.first = 1'b0;
        end
        // hold-off fires before the buffer fills to cover the partner's lag
        next_s.ack_o = !(rx_on && next_s.first &&
            next_s.level >= CNT_NEAR);
    end

    always_ff @(posedge CLK_SYS) begin
        if (!RST_N) begin
            s <= '{st: LPC_TX_IDLE, cnt: HALF_ZERO, clk_o: 1'b0,
                dat_o: DATA_RST, drv_tx: 1'b0, drv_rx: 1'b0, ack_o: 1'b1,
                ack_s: 2'h3, clk_s: 2'h0, clk_d: 1'b0, dat_s1: DATA_RST,
                dat_s2: DATA_RST, first: 1'b0, wr_ptr: '0, rd_ptr: '0,
                level: CNT_ZERO};
        end else begin
            s <= next_s;
        end
    end

    lpc_rx_buf #(
        .WIDTH(DATA_W),
        .DEPTH(DEPTH),
        .AW(AW)
    ) u_buf (
        .clk(CLK_SYS),
        .we(rx_wr),
        .waddr(s.wr_ptr),
        .wdata(s.dat_s2),
        .raddr(next_s.rd_ptr),
        .rdata(RX_DATA)
    );

    assign RX_VALID = s.level != CNT_ZERO;
    assign LINK_CLOCK_OUT = s.clk_o;
    assign LINK_CLOCK_OE_N = !s.drv_tx;
    assign LINK_DATA_OUT = s.dat_o;
    assign LINK_DATA_OE_N = !s.drv_tx;
    assign LINK_ACKNOWLEDGE_OUT = s.ack_o;
    assign LINK_ACKNOWLEDGE_OE_N = !s.drv_rx;
endmodule : lpc_link_port
`default_nettype wire

// ===== lpc_partner.sv
// far-end link port model: receiver with throttle and byte sender
`timescale 1ns/10ps
`default_nettype none
module lpc_partner (
    // clock, throttle command and wire levels
    input wire logic clk,
    input wire logic hold,
    input wire logic clk_w,
    input wire logic ack_w,
    input wire logic [7:0] dat_w,
    // lines driven when the block is not driving them
    output logic ack,
    output logic lclk,
    output logic [7:0] ldat
);
    logic [7:0] rxq[$];
    logic [7:0] txq[$];
    assign ack = !hold;
    always @(negedge clk_w) rxq.push_back(dat_w);
    // clock rests low between bytes; data goes stale once hold runs out
    initial begin
        lclk = 1'b0;
        ldat = 8'h00;
        forever begin
            @(posedge clk);
            if (txq.size() != 0) begin
                lclk <= 1'b1;
                ldat <= txq.pop_front();
                repeat (4) @(posedge clk);
                while (!ack_w) @(posedge clk);
                lclk <= 1'b0;
                repeat (3) @(posedge clk);
                ldat <= ~ldat;
            end
        end
    end
endmodule : lpc_partner
`default_nettype wire

// ===== lpc_link_port_chk.sv
// link port checker and its bind
`timescale 1ns/10ps
`default_nettype none
module lpc_link_port_chk (
    // watched ports
    input wire logic CLK_SYS,
    input wire logic RST_N,
    input wire logic TX_VALID,
    input wire logic TX_READY,
    input wire logic RX_VALID,
    input wire logic [lpc_pkg::DIV_W-1:0] LINK_DIVIDER_REGISTER,
    input wire logic LINK_CLOCK_IN,
    input wire logic LINK_CLOCK_OUT,
    input wire logic LINK_ACKNOWLEDGE_IN,
    input wire logic LINK_ACKNOWLEDGE_OUT,
    input wire logic LINK_ACKNOWLEDGE_OE_N,
    input wire logic [lpc_pkg::DATA_W-1:0] LINK_DATA_OUT,
    input wire logic LINK_DATA_OE_N
);
    import lpc_pkg::*;
    logic [HALF_W-1:0] hi_cnt;
    default clocking cb @(posedge CLK_SYS); endclocking
    default disable iff (!RST_N);
    always_ff @(posedge CLK_SYS) hi_cnt <= (RST_N && LINK_CLOCK_OUT) ?
        hi_cnt + HALF_ONE : HALF_ZERO;
    hi_width_a: assert property ($fell(LINK_CLOCK_OUT) |-> hi_cnt >=
        ((LINK_DIVIDER_REGISTER == 8'h00) ? HALF_ONE :
        {LINK_DIVIDER_REGISTER, 1'b0})) else $error("clock high too short");
    lo_width_a: assert property ($rose(LINK_CLOCK_OUT) &&
        LINK_DIVIDER_REGISTER != 8'h00 |-> !$past(LINK_CLOCK_OUT, 2))
        else $error("clock low too short");
    start_cause_a: assert property ($rose(LINK_CLOCK_OUT) |->
        $past(TX_VALID && TX_READY)) else $error("clock without byte");
    data_hold_a: assert property (!LINK_DATA_OE_N &&
        !$rose(LINK_CLOCK_OUT) |-> $stable(LINK_DATA_OUT))
        else $error("data moved off rising edge");
    ack_hold_a: assert property ((!LINK_ACKNOWLEDGE_IN)[*4] ##0
        LINK_CLOCK_OUT |=> LINK_CLOCK_OUT) else $error("fell while held");
    ack_resume_a: assert property (LINK_CLOCK_OUT &&
        $past(LINK_CLOCK_OUT, 4) && LINK_DIVIDER_REGISTER == 8'h01 &&
        $rose(LINK_ACKNOWLEDGE_IN) |-> ##[1:4] !LINK_CLOCK_OUT)
        else $error("no resume after release");
    ack_low_a: assert property (!LINK_ACKNOWLEDGE_OE_N &&
        !LINK_ACKNOWLEDGE_OUT |-> RX_VALID) else $error("ack low, empty");
    rx_fall_a: assert property ($fell(LINK_CLOCK_IN) &&
        !LINK_ACKNOWLEDGE_OE_N && !RX_VALID |-> ##[2:6] RX_VALID)
        else $error("fall edge byte lost");
    cover property (LINK_CLOCK_OUT && !LINK_ACKNOWLEDGE_IN);
    cover property (!LINK_ACKNOWLEDGE_OE_N && !LINK_ACKNOWLEDGE_OUT);
    cover property ($fell(LINK_CLOCK_OUT) && LINK_DIVIDER_REGISTER == 8'h00);
endmodule : lpc_link_port_chk
bind lpc_link_port lpc_link_port_chk u_chk (.*);
`default_nettype wire

// ===== lpc_link_port_tb.sv
// self-checking bench for the link port
`timescale 1ns/10ps
`default_nettype none
module lpc_link_port_tb;
    logic CLK_SYS = 1'b0, RST_N = 1'b0, TX_ENABLE = 1'b0, RX_ENABLE = 1'b0;
    logic TX_VALID = 1'b0, RX_READY = 1'b0, hold = 1'b0, TX_READY, RX_VALID;
    logic [7:0] LINK_DIVIDER_REGISTER = 8'h01, TX_DATA = 8'h00, RX_DATA;
    logic LINK_CLOCK_OUT, LINK_CLOCK_OE_N, p_clk, clk_w, p_ack, ack_w;
    logic LINK_ACKNOWLEDGE_OUT, LINK_ACKNOWLEDGE_OE_N, LINK_DATA_OE_N;
    logic [7:0] LINK_DATA_OUT, p_dat, dat_w;
    int error_cnt = 0, cmp_count = 0, cyc = 0;
    time rt[$];
    assign clk_w = LINK_CLOCK_OE_N ? p_clk : LINK_CLOCK_OUT;
    assign ack_w = LINK_ACKNOWLEDGE_OE_N ? p_ack : LINK_ACKNOWLEDGE_OUT;
    assign dat_w = LINK_DATA_OE_N ? p_dat : LINK_DATA_OUT;
    always #5 CLK_SYS = ~CLK_SYS;
    always @(posedge LINK_CLOCK_OUT) rt.push_back($time);
    lpc_link_port u_dut (.CLK_SYS(CLK_SYS), .RST_N(RST_N),
        .TX_ENABLE(TX_ENABLE), .RX_ENABLE(RX_ENABLE),
        .LINK_DIVIDER_REGISTER(LINK_DIVIDER_REGISTER), .TX_DATA(TX_DATA),
        .TX_VALID(TX_VALID), .TX_READY(TX_READY), .RX_DATA(RX_DATA),
        .RX_VALID(RX_VALID), .RX_READY(RX_READY), .LINK_CLOCK_IN(clk_w),
        .LINK_CLOCK_OUT(LINK_CLOCK_OUT), .LINK_CLOCK_OE_N(LINK_CLOCK_OE_N),
        .LINK_ACKNOWLEDGE_IN(ack_w),
        .LINK_ACKNOWLEDGE_OUT(LINK_ACKNOWLEDGE_OUT),
        .LINK_ACKNOWLEDGE_OE_N(LINK_ACKNOWLEDGE_OE_N), .LINK_DATA_IN(dat_w),
        .LINK_DATA_OUT(LINK_DATA_OUT), .LINK_DATA_OE_N(LINK_DATA_OE_N));
    lpc_partner u_prt (.clk(CLK_SYS), .hold(hold), .clk_w(clk_w),
        .ack_w(ack_w), .dat_w(dat_w), .ack(p_ack), .lclk(p_clk), .ldat(p_dat));
    task automatic chk(input string s, input logic [15:0] e, g);
        cmp_count++;
        if (g !== e) begin
            error_cnt++;
            $display("ERROR %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic send(input logic [7:0] b);
        TX_DATA <= b;
        TX_VALID <= 1'b1;
        do @(negedge CLK_SYS); while (!TX_READY);
        @(posedge CLK_SYS);
    endtask : send
    task automatic tx_case(input logic [7:0] dv);
        @(posedge CLK_SYS);
        LINK_DIVIDER_REGISTER <= dv;
        TX_ENABLE <= 1'b1;
        rt.delete();
        u_prt.rxq.delete();
        send(dv ^ 8'h5A);
        send(dv ^ 8'hA5);
        TX_VALID <= 1'b0;
        repeat (4 * dv + 12) @(posedge CLK_SYS);
        chk("period", (dv == 0) ? 16'd2 : 16'd4 * dv, 16'((rt[1] - rt[0]) / 10));
        chk("rises", 16'd2, 16'(rt.size()));
        chk("byte0", {8'h00, dv ^ 8'h5A}, {8'h00, u_prt.rxq[0]});
        chk("byte1", {8'h00, dv ^ 8'hA5}, {8'h00, u_prt.rxq[1]});
    endtask : tx_case
    task automatic tx_hold;
        @(posedge CLK_SYS);
        LINK_DIVIDER_REGISTER <= 8'h01;
        RX_ENABLE <= 1'b1;
        hold <= 1'b1;
        send(8'hC3);
        TX_VALID <= 1'b0;
        repeat (12) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk("held", 16'h0001, {15'h0000, LINK_CLOCK_OUT});
        chk("tx wins", 16'h0001, {15'h0000, LINK_ACKNOWLEDGE_OE_N});
        @(posedge CLK_SYS);
        hold <= 1'b0;
        repeat (5) @(posedge CLK_SYS);
        @(negedge CLK_SYS);
        chk("resumed", 16'h0000, {15'h0000, LINK_CLOCK_OUT});
        chk("held byte", 16'h00C3, {8'h00, u_prt.rxq[$]});
    endtask : tx_hold
    task automatic rx_case;
        @(posedge CLK_SYS);
        TX_ENABLE <= 1'b0;
        RX_ENABLE <= 1'b1;
        repeat (2) @(posedge CLK_SYS);
        for (int i = 0; i < 14; i++) u_prt.txq.push_back(8'h30 + i[7:0]);
        repeat (200) @(posedge CLK_SYS);
        chk("ack low", 16'd0, {15'd0, LINK_ACKNOWLEDGE_OUT});
        chk("throttled", 16'd1, {15'd0, u_prt.txq.size() != 0});
        RX_READY <= 1'b1;
        for (int i = 0; i < 14; i++) begin
            do @(negedge CLK_SYS); while (!RX_VALID);
            chk("rx byte", 16'(8'h30 + i), {8'h00, RX_DATA});
            @(posedge CLK_SYS);
        end
        chk("ack high", 16'd1, {15'd0, LINK_ACKNOWLEDGE_OUT});
        RX_ENABLE <= 1'b0;
        repeat (3) @(posedge CLK_SYS);
        chk("idle", 16'd7, {13'd0, LINK_CLOCK_OE_N, LINK_DATA_OE_N, LINK_ACKNOWLEDGE_OE_N});
    endtask : rx_case
    task automatic test_done;
        $display("compares %0d errors %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : test_done
    always @(posedge CLK_SYS) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            test_done();
        end
    end
    initial begin
        repeat (8) @(posedge CLK_SYS);
        RST_N <= 1'b1;
        tx_case(8'h00);
        tx_case(8'h01);
        tx_case(8'hFF);
        tx_hold();
        rx_case();
        test_done();
    end
endmodule : lpc_link_port_tb
`default_nettype wire
